/* File: hw/cpu_status_control_reg.sv */
// Processor status and control register with run, step, suspend and reset-cause logic.
// Assumes the core pulses its events for one clock, and sys_rst is the power-on reset.
`timescale 1ns/1ps

// Operation
// - halt instruction clears run bit 0, stopping after the current instruction.
// - once halted, only power-on or watchdog reset restarts the processor.
// - with single-step bit 1 set, run one instruction then clear run.
// - bit 2 reads interrupt enable; writes to it change nothing.
// - apart from resets, only disable, enable and return-from-interrupt instructions and interrupt acknowledge change interrupt enable.
// - writing one to bit 3 halts the core and enters low-power suspend.
// - pending interrupt or bus activity ends suspend; execution continues after the write.
// - suspend write discarded if bus activity or interrupt already pending.
// - power-on flag set selects 128us start-up, clear selects 128ms.
// - SE0 longer than 8us sets bit 5 and raises bus-reset interrupt.
// - bus reset only interrupts; the core is not reset.
// - over 8ms without watchdog clear gives watchdog reset and sets bit 6.
// - bit 7 set when interrupt recognised, cleared by interrupt acknowledge.
// - power-on reset loads 00010001.
// - watchdog reset loads 01000001.
// - acknowledge disables interrupts, then clears the latch, then calls the vector.
module cpu_status_control_reg #(
   parameter int unsigned WDT_LIMIT = psc_pkg::WDT_CYCLES,
   parameter int unsigned WAKE_SHORT = psc_pkg::WAKE_SHORT_CYCLES,
   parameter int unsigned WAKE_LONG = psc_pkg::WAKE_LONG_CYCLES,
   parameter int unsigned SE0_LIMIT = psc_pkg::SE0_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire psc_pkg::io_req_type io,
   input wire psc_pkg::core_evt_type core,
   input wire logic usb_se0,
   output logic [7:0] io_rdata,
   output logic cpu_run,
   output logic irq_enable,
   output logic suspend_mode,
   output logic latch_clear,
   output logic vector_call,
   output logic bus_reset_irq,
   output logic watchdog_reset,
   output logic power_on_flag
);

   ////////////////////////////////////////////////////////////////////////////////
   // limits at counter width
   localparam logic [psc_pkg::CNT_W-1:0] WDT_LIM = psc_pkg::CNT_W'(WDT_LIMIT);
   localparam logic [psc_pkg::CNT_W-1:0] WAKE_S = psc_pkg::CNT_W'(WAKE_SHORT);
   localparam logic [psc_pkg::CNT_W-1:0] WAKE_L = psc_pkg::CNT_W'(WAKE_LONG);
   localparam logic [psc_pkg::SE0_CNT_W-1:0] SE0_LIM = psc_pkg::SE0_CNT_W'(SE0_LIMIT);
   localparam logic [psc_pkg::CNT_W-1:0] CNT_ONE = psc_pkg::CNT_W'(1);
   localparam logic [psc_pkg::SE0_CNT_W-1:0] SE0_ONE = psc_pkg::SE0_CNT_W'(1);

   ////////////////////////////////////////////////////////////////////////////////
   // address decode shared by reads and writes
   function automatic logic psc_hit(input logic strobe, input logic [7:0] addr);
      psc_hit = strobe && (addr == psc_pkg::PSC_ADDR);
   endfunction : psc_hit

   psc_pkg::psc_state_type q;
   psc_pkg::psc_state_type d;
   logic wr_hit;
   logic rd_hit;
   logic wake_cause;
   logic [7:0] view;

   assign wr_hit = psc_hit(io.io_write, io.addr);
   assign rd_hit = psc_hit(io.io_read, io.addr);
   assign wake_cause = core.irq_request || core.bus_activity;

   // interrupt enable lives outside the stored byte
   always_comb begin
      view = q.psc;
      view[psc_pkg::B_IE] = q.ie;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      d.bus_rst_irq = 1'b0;
      d.wdt_rst = 1'b0;
      d.latch_clr = 1'b0;
      d.vec_call = 1'b0;

      // register read returns a snapshot one cycle later
      if (rd_hit) begin
         d.rdata = view;
      end

      // firmware write of the writable fields
      if (wr_hit) begin
         d.psc[psc_pkg::B_RUN] = io.wdata[psc_pkg::B_RUN];
         d.psc[psc_pkg::B_STEP] = io.wdata[psc_pkg::B_STEP];
         d.psc[psc_pkg::B_POR] = io.wdata[psc_pkg::B_POR];
         d.psc[psc_pkg::B_USBRST] = io.wdata[psc_pkg::B_USBRST];
         d.psc[psc_pkg::B_WDT] = io.wdata[psc_pkg::B_WDT];
         d.psc[psc_pkg::B_SUSP] = 1'b0;
         if (io.wdata[psc_pkg::B_SUSP] && !wake_cause && q.st == psc_pkg::ST_RUN) begin
            d.psc[psc_pkg::B_SUSP] = 1'b1;
            d.st = psc_pkg::ST_SUSP;
         end
      end

      // halt instruction or single step ends at instruction boundary
      if (q.st == psc_pkg::ST_RUN && core.instr_done) begin
         if (core.halt_instr || q.psc[psc_pkg::B_STEP]) begin
            d.psc[psc_pkg::B_RUN] = 1'b0;
         end
      end

      // a cleared run bit stops the core until a reset
      if (d.st == psc_pkg::ST_RUN && !d.psc[psc_pkg::B_RUN]) begin
         d.st = psc_pkg::ST_HALT;
      end

      // interrupt enable: instructions and acknowledge only
      if (core.disable_irq_instruction) begin
         d.ie = 1'b0;
      end
      if (core.enable_irq_instruction || core.return_from_irq_instruction) begin
         d.ie = 1'b1;
      end

      // acknowledge sequence: disable, clear latch, call vector
      case (q.ack_stage)
         2'b00: begin
            if (core.irq_ack) begin
               d.ie = 1'b0;
               d.ack_stage = 2'b01;
            end
         end
         2'b01: begin
            d.latch_clr = 1'b1;
            d.ack_stage = 2'b10;
         end
         2'b10: begin
            d.vec_call = 1'b1;
            d.ack_stage = 2'b00;
         end
         default: begin
            d.ack_stage = 2'b00;
         end
      endcase

      // pending flag: recognition wins over acknowledge in the same cycle
      if (core.irq_ack) begin
         d.psc[psc_pkg::B_IRQ] = 1'b0;
      end
      if (core.irq_request && q.ie && core.instr_done && q.st == psc_pkg::ST_RUN) begin
         d.psc[psc_pkg::B_IRQ] = 1'b1;
      end

      // suspend and start-up
      case (q.st)
         psc_pkg::ST_SUSP: begin
            if (wake_cause) begin
               d.psc[psc_pkg::B_SUSP] = 1'b0;
               d.st = psc_pkg::ST_WAKE;
               d.wake_cnt = q.psc[psc_pkg::B_POR] ? WAKE_S : WAKE_L;
            end
         end
         psc_pkg::ST_WAKE: begin
            if (q.wake_cnt <= CNT_ONE) begin
               d.wake_cnt = '0;
               d.st = psc_pkg::ST_RUN;
            end else begin
               d.wake_cnt = q.wake_cnt - CNT_ONE;
            end
         end
         psc_pkg::ST_RUN: begin
         end
         psc_pkg::ST_HALT: begin
         end
         default: begin
            d.st = psc_pkg::ST_HALT;
         end
      endcase

      // bus reset: SE0 held beyond the limit flags once per event
      if (usb_se0) begin
         if (q.se0_cnt != SE0_LIM) begin
            d.se0_cnt = q.se0_cnt + SE0_ONE;
         end else if (!q.se0_seen) begin
            d.se0_seen = 1'b1;
            d.psc[psc_pkg::B_USBRST] = 1'b1;
            d.bus_rst_irq = 1'b1;
         end
      end else begin
         d.se0_cnt = '0;
         d.se0_seen = 1'b0;
      end

      // watchdog stops during suspend and start-up
      if (core.wdt_clear || q.st == psc_pkg::ST_SUSP || q.st == psc_pkg::ST_WAKE) begin
         d.wdt_cnt = '0;
      end else if (q.wdt_cnt != WDT_LIM) begin
         d.wdt_cnt = q.wdt_cnt + CNT_ONE;
      end else begin
         // one cycle past the limit: reset the core
         d.wdt_cnt = '0;
         d.wdt_rst = 1'b1;
         d.psc = psc_pkg::PSC_WDT_VAL;
         d.st = psc_pkg::ST_RUN;
         d.ie = 1'b0;
         d.ack_stage = 2'b00;
         d.wake_cnt = '0;
         d.latch_clr = 1'b0;
         d.vec_call = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q.st <= psc_pkg::ST_RUN;
         q.psc <= psc_pkg::PSC_POR_VAL;
         q.ie <= 1'b0;
         q.wdt_cnt <= '0;
         q.wake_cnt <= '0;
         q.se0_cnt <= '0;
         q.se0_seen <= 1'b0;
         q.ack_stage <= 2'b00;
         q.rdata <= 8'h00;
         q.bus_rst_irq <= 1'b0;
         q.wdt_rst <= 1'b0;
         q.latch_clr <= 1'b0;
         q.vec_call <= 1'b0;
      end else if (ce) begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign io_rdata = q.rdata;
   assign cpu_run = (q.st == psc_pkg::ST_RUN);
   assign irq_enable = q.ie;
   assign suspend_mode = (q.st == psc_pkg::ST_SUSP);
   assign latch_clear = q.latch_clr;
   assign vector_call = q.vec_call;
   assign bus_reset_irq = q.bus_rst_irq;
   assign watchdog_reset = q.wdt_rst;
   assign power_on_flag = q.psc[psc_pkg::B_POR];

endmodule : cpu_status_control_reg

/* File: hw/psc_pkg.sv */
// Constants, state encoding and carriers for the processor status and control register.
// Assumes a single 250 MHz core clock and an I/O port with eight-bit addresses.
package psc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and times
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned SE0_TIME_NS = 8000;
   localparam int unsigned WDT_TIME_MS = 8;
   localparam int unsigned WAKE_SHORT_US = 128;
   localparam int unsigned WAKE_LONG_MS = 128;
   localparam int unsigned SE0_CYCLES = (SE0_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned WDT_CYCLES = 32'((WDT_TIME_MS * 64'd1000000000) / CLK_PERIOD_PS);
   localparam int unsigned WAKE_SHORT_CYCLES = (WAKE_SHORT_US * 1000000) / CLK_PERIOD_PS;
   localparam int unsigned WAKE_LONG_CYCLES = 32'((WAKE_LONG_MS * 64'd1000000000) / CLK_PERIOD_PS);
   localparam int unsigned CNT_W = 26;
   localparam int unsigned SE0_CNT_W = 12;

   ////////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] PSC_ADDR = 8'hFF;
   localparam logic [7:0] PSC_POR_VAL = 8'h11;
   localparam logic [7:0] PSC_WDT_VAL = 8'h41;
   localparam int unsigned B_RUN = 0;
   localparam int unsigned B_STEP = 1;
   localparam int unsigned B_IE = 2;
   localparam int unsigned B_SUSP = 3;
   localparam int unsigned B_POR = 4;
   localparam int unsigned B_USBRST = 5;
   localparam int unsigned B_WDT = 6;
   localparam int unsigned B_IRQ = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_HALT = 4'h2,
      ST_SUSP = 4'h4,
      ST_WAKE = 4'h8
   } cpu_state_type;

   typedef struct packed {
      logic io_write;
      logic io_read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } io_req_type;

   typedef struct packed {
      logic instr_done;
      logic halt_instr;
      logic disable_irq_instruction;
      logic enable_irq_instruction;
      logic return_from_irq_instruction;
      logic irq_ack;
      logic irq_request;
      logic bus_activity;
      logic wdt_clear;
   } core_evt_type;

   typedef struct packed {
      cpu_state_type st;
      logic [7:0] psc;
      logic ie;
      logic [CNT_W-1:0] wdt_cnt;
      logic [CNT_W-1:0] wake_cnt;
      logic [SE0_CNT_W-1:0] se0_cnt;
      logic se0_seen;
      logic [1:0] ack_stage;
      logic [7:0] rdata;
      logic bus_rst_irq;
      logic wdt_rst;
      logic latch_clr;
      logic vec_call;
   } psc_state_type;

endpackage : psc_pkg

/* File: sim/psc_checker.sv */
// concurrent checks on the processor status and control register ports
// bound into cpu_status_control_reg; one clock, reset sys_rst active high
`timescale 1ns/1ps
module psc_checker #(
   parameter int unsigned SE0_LIMIT = psc_pkg::SE0_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire psc_pkg::io_req_type io,
   input wire psc_pkg::core_evt_type core,
   input wire logic usb_se0,
   input wire logic cpu_run,
   input wire logic irq_enable,
   input wire logic suspend_mode,
   input wire logic latch_clear,
   input wire logic vector_call,
   input wire logic bus_reset_irq,
   input wire logic watchdog_reset
);
   logic [15:0] se0_q;
   logic psc_wr;
   logic pend;
   logic ie_cmd;
   assign psc_wr = ce && io.io_write && io.addr == psc_pkg::PSC_ADDR;
   assign pend = core.irq_request || core.bus_activity;
   assign ie_cmd = core.disable_irq_instruction || core.enable_irq_instruction
      || core.return_from_irq_instruction || core.irq_ack;
   // length of the current se0 episode
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) se0_q <= '0;
      else if (ce) se0_q <= usb_se0 ? se0_q + 16'h0001 : 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_halt_stop:
      assert property (ce && core.instr_done && core.halt_instr && cpu_run |=> !cpu_run)
      else $error("run kept after halt");
   chk_susp_enter:
      assert property (psc_wr && io.wdata[3] && io.wdata[0] && cpu_run && !pend
         |=> suspend_mode && !cpu_run) else $error("suspend not entered");
   chk_susp_refuse:
      assert property (psc_wr && io.wdata[3] && pend |=> !suspend_mode)
      else $error("suspend taken while pending");
   chk_susp_wake:
      assert property (ce && suspend_mode && pend |=> !suspend_mode)
      else $error("suspend not ended");
   chk_ack_order:
      assert property (ce && core.irq_ack |=> !irq_enable ##1 latch_clear ##1 vector_call)
      else $error("acknowledge order wrong");
   chk_ie_hold:
      assert property (ce && !ie_cmd |=> $stable(irq_enable) || watchdog_reset)
      else $error("interrupt enable moved");
   chk_ei_set:
      assert property (ce && core.enable_irq_instruction && !core.irq_ack |=> irq_enable)
      else $error("enable instruction ignored");
   chk_se0_time:
      assert property ($rose(bus_reset_irq) |-> se0_q inside {[SE0_LIMIT+1:SE0_LIMIT+3]}
         ##1 !bus_reset_irq) else $error("bus reset timing wrong");
   chk_wdt_clear:
      assert property (ce && core.wdt_clear |=> !watchdog_reset [*8])
      else $error("watchdog fired after clear");
   cover property (suspend_mode);
   cover property (vector_call);
   cover property (watchdog_reset);
endmodule : psc_checker

bind cpu_status_control_reg psc_checker #(.SE0_LIMIT(SE0_LIMIT)) i_chk (
   .clk(clk), .sys_rst(sys_rst), .ce(ce), .io(io), .core(core), .usb_se0(usb_se0),
   .cpu_run(cpu_run), .irq_enable(irq_enable), .suspend_mode(suspend_mode),
   .latch_clear(latch_clear), .vector_call(vector_call), .bus_reset_irq(bus_reset_irq),
   .watchdog_reset(watchdog_reset));

/* File: sim/tb_top.sv */
// self-checking bench for the processor status and control register
// drives all ports itself; long counts shortened through parameters
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned WDT = 50;
   localparam int unsigned SE0 = 8;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic usb_se0 = 1'b0;
   logic wd_on = 1'b0;
   logic r;
   psc_pkg::io_req_type io = '0;
   psc_pkg::core_evt_type ev = '0;
   logic [7:0] io_rdata;
   logic [7:0] w;
   logic [7:0] exp_q[$];
   logic cpu_run, irq_enable, suspend_mode, latch_clear, vector_call;
   logic bus_reset_irq, watchdog_reset, power_on_flag;
   int error_cnt = 0;
   int check_count = 0;
   int n;
   int k;
   cpu_status_control_reg #(.WDT_LIMIT(WDT), .WAKE_SHORT(5), .WAKE_LONG(40),
      .SE0_LIMIT(SE0)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .io(io), .core(ev), .usb_se0(usb_se0),
      .io_rdata(io_rdata), .cpu_run(cpu_run), .irq_enable(irq_enable),
      .suspend_mode(suspend_mode), .latch_clear(latch_clear), .vector_call(vector_call),
      .bus_reset_irq(bus_reset_irq), .watchdog_reset(watchdog_reset),
      .power_on_flag(power_on_flag));
   always #2 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want) begin
         error_cnt++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : chk
   // every wait passes here; watchdog clear pulses every other cycle
   task automatic tick();
      @(posedge clk);
      #1;
      ev.wdt_clear = wd_on && !ev.wdt_clear;
   endtask : tick
   task automatic ev_pulse(input psc_pkg::core_evt_type m);
      ev = ev | m;
      tick();
      ev = ev & ~m;
   endtask : ev_pulse
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      io = '{wr, !wr, a, d};
      tick();
      io = '0;
      tick();
   endtask : acc
   task automatic rd(input logic [7:0] e);
      exp_q.push_back(e);
      acc(1'b0, psc_pkg::PSC_ADDR, 8'h00);
   endtask : rd
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   // read results compared half a cycle after the read edge
   always @(posedge clk) begin
      r = io.io_read && io.addr == psc_pkg::PSC_ADDR;
      #2;
      if (r) chk(io_rdata, exp_q.pop_front());
   end
   initial begin
      #20000;
      error_cnt++;
      conclude();
   end
   initial begin
      void'($urandom(32'hA0D5BFD1));
      repeat (2) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      wd_on = 1'b1;
      rd(psc_pkg::PSC_POR_VAL);
      chk(8'(cpu_run & power_on_flag & !irq_enable), 8'h01);
      for (k = 0; k < 4; k++) begin
         w = 8'($urandom) & 8'hF5 | 8'h01;
         acc(1'b1, psc_pkg::PSC_ADDR, w);
         acc(1'b1, 8'($urandom % 255), 8'h00);
         rd(w & 8'h71);
      end
      // clock enable low: a write must leave no trace
      ce = 1'b0;
      acc(1'b1, psc_pkg::PSC_ADDR, w ^ 8'h70);
      ce = 1'b1;
      rd(w & 8'h71);
      acc(1'b1, psc_pkg::PSC_ADDR, 8'h11);
      ev_pulse('{enable_irq_instruction:1'b1, default:1'b0});
      acc(1'b1, psc_pkg::PSC_ADDR, 8'h11);
      rd(8'h15);
      ev.irq_request = 1'b1;
      ev_pulse('{instr_done:1'b1, default:1'b0});
      ev.irq_request = 1'b0;
      rd(8'h95);
      ev_pulse('{irq_ack:1'b1, default:1'b0});
      rd(8'h11);
      tick();
      ev_pulse('{return_from_irq_instruction:1'b1, default:1'b0});
      rd(8'h15);
      ev_pulse('{disable_irq_instruction:1'b1, default:1'b0});
      rd(8'h11);
      $display("registers and interrupt view done");
      ev.bus_activity = 1'b1;
      acc(1'b1, psc_pkg::PSC_ADDR, 8'h19);
      chk(8'(suspend_mode | !cpu_run), 8'h00);
      ev.bus_activity = 1'b0;
      rd(8'h11);
      for (k = 0; k < 2; k++) begin
         acc(1'b1, psc_pkg::PSC_ADDR, (k != 0) ? 8'h09 : 8'h19);
         chk(8'({suspend_mode, cpu_run}), 8'h02);
         tick();
         ev.irq_request = (k == 0);
         ev.bus_activity = (k != 0);
         tick();
         ev.irq_request = 1'b0;
         ev.bus_activity = 1'b0;
         chk(8'(suspend_mode), 8'h00);
         n = 0;
         while (cpu_run !== 1'b1 && n < 200) begin
            tick();
            n++;
         end
         chk(8'((k != 0) ? n > 30 : n < 20), 8'h01);
      end
      acc(1'b1, psc_pkg::PSC_ADDR, 8'h11);
      $display("suspend done");
      // halt instruction first, then a single step, each ended by the watchdog
      for (k = 0; k < 2; k++) begin
         if (k != 0) begin
            acc(1'b1, psc_pkg::PSC_ADDR, 8'h03);
            chk(8'(cpu_run), 8'h01);
         end
         wd_on = 1'b0;
         ev_pulse('{instr_done:1'b1, halt_instr:(k == 0), wdt_clear:1'b1, default:1'b0});
         tick();
         n = 1;
         while (watchdog_reset !== 1'b1 && n < 200) begin
            chk(8'(cpu_run), 8'h00);
            tick();
            n++;
         end
         chk(8'(n >= WDT - 1 && n <= WDT + 4), 8'h01);
         wd_on = 1'b1;
         tick();
         chk(8'(cpu_run), 8'h01);
         rd(psc_pkg::PSC_WDT_VAL);
      end
      $display("halt and watchdog done");
      usb_se0 = 1'b1;
      k = 0;
      repeat (SE0 + 5) begin
         tick();
         k += int'(bus_reset_irq);
      end
      usb_se0 = 1'b0;
      chk(8'(k), 8'h01);
      chk(8'(cpu_run), 8'h01);
      rd(psc_pkg::PSC_WDT_VAL | 8'h20);
      $display("bus reset done");
      tick();
      conclude();
   end
endmodule : tb_top
